// [include/aoesr_pkg.sv]
package aoesr_pkg;

    // Register addresses of the output and status group
    localparam logic [7:0] ADDR_ACCEL_X_LOW = 8'h28;
    localparam logic [7:0] ADDR_ACCEL_X_HIGH = 8'h29;
    localparam logic [7:0] ADDR_ACCEL_Y_LOW = 8'h2a;
    localparam logic [7:0] ADDR_ACCEL_Y_HIGH = 8'h2b;
    localparam logic [7:0] ADDR_ACCEL_Z_LOW = 8'h2c;
    localparam logic [7:0] ADDR_ACCEL_Z_HIGH = 8'h2d;
    localparam logic [7:0] ADDR_EMBEDDED_EVENT_STATUS = 8'h35;
    localparam logic [7:0] ADDR_STATE_MACHINE_STATUS_LOW = 8'h36;
    localparam logic [7:0] ADDR_STATE_MACHINE_STATUS_HIGH = 8'h37;
    // Configuration addresses that steer the two chains (held elsewhere)
    localparam logic [7:0] ADDR_ACCEL_USER_CONFIG = 8'h10;
    localparam logic [7:0] ADDR_STABILIZATION_CONFIG = 8'h72;

    // Bit positions inside the embedded event status byte
    localparam int POS_LONG_COUNTER_TIMEOUT = 7;
    localparam int POS_SIGNIFICANT_MOTION = 5;
    localparam int POS_TILT = 4;
    localparam int POS_STEP = 3;

    // Widths
    localparam int AXIS_W = 16;
    localparam int BYTE_W = 8;
    localparam int EMB_FLAGS = 4;
    localparam int MACHINES = 16;

    // Values after reset
    localparam logic [AXIS_W-1:0] AXIS_RESET = 16'h0000;
    localparam logic [BYTE_W-1:0] BYTE_RESET = 8'h00;
    localparam logic [1:0] AXIS_SEL_RESET = 2'h0;

    // One acceleration sample, three axes of two's complement
    typedef struct packed {
        logic [AXIS_W-1:0] x;
        logic [AXIS_W-1:0] y;
        logic [AXIS_W-1:0] z;
    } aoesr_sample_t;

    // One register access from the serial port logic
    typedef struct packed {
        logic write;
        logic aux;
        logic [7:0] addr;
        logic [BYTE_W-1:0] wdata;
    } aoesr_req_t;

    // Embedded function events, one-cycle pulses
    typedef struct packed {
        logic long_counter;
        logic sig_motion;
        logic tilt;
        logic step;
    } aoesr_emb_evt_t;

endpackage

// [logic/aoesr_flag_latch.sv]
`timescale 1ns/1ps
// Sticky event flags, cleared per bit, a new event beating the clear
module aoesr_flag_latch #(
    parameter int WIDTH = 4
) (
    input wire logic sys_clk_i,
    input wire logic reset_i,
    input wire logic [WIDTH-1:0] set_i,
    input wire logic [WIDTH-1:0] clear_i,
    output logic [WIDTH-1:0] flags_o
);
    import aoesr_pkg::*;

    logic [WIDTH-1:0] flags_q;

    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_flag
            // Set wins so an event in the clearing cycle is kept
            always_ff @(posedge sys_clk_i) begin
                if (reset_i) begin
                    flags_q[i] <= 1'b0;
                end else if (set_i[i]) begin
                    flags_q[i] <= 1'b1;
                end else if (clear_i[i]) begin
                    flags_q[i] <= 1'b0;
                end
            end
        end
    endgenerate

    assign flags_o = flags_q;

endmodule

// [logic/aoesr_regs.sv]
// Function
// - X acceleration word at 28h/29h, read-only
// - Y acceleration word at 2Ah/2Bh, read-only
// - Z acceleration word at 2Ch/2Dh, read-only
// - Primary port reads return user chain
// - Auxiliary port reads return stabilization chain
// - Each axis multiplexed by requesting port
// - Embedded event byte at 35h, spare bits fixed zeros
// - Significant motion flag set on event
// - Tilt flag set on event
// - Step flag set on event
// - Machines eight..one in byte at 36h
// - Machines nine..sixteen in byte at 37h
`timescale 1ns/1ps
module aoesr_regs (
    input wire logic sys_clk_i,
    input wire logic reset_i,
    // Register access from the serial port logic
    input wire logic req_valid_i,
    input wire aoesr_pkg::aoesr_req_t req_i,
    output logic rsp_valid_o,
    output logic [aoesr_pkg::BYTE_W-1:0] rsp_data_o,
    output logic rsp_hit_o,
    output logic write_dropped_o,
    // Sample streams of the two acceleration chains
    input wire logic user_sample_valid_i,
    input wire aoesr_pkg::aoesr_sample_t user_sample_i,
    input wire logic stab_sample_valid_i,
    input wire aoesr_pkg::aoesr_sample_t stab_sample_i,
    output logic user_fresh_o,
    output logic stab_fresh_o,
    // Event pulses from embedded functions and state machines
    input wire aoesr_pkg::aoesr_emb_evt_t emb_event_i,
    input wire logic [aoesr_pkg::MACHINES-1:0] machine_event_i,
    output logic [aoesr_pkg::BYTE_W-1:0] embedded_event_status_o,
    output logic [aoesr_pkg::MACHINES-1:0] state_machine_status_o
);
    import aoesr_pkg::*;

    // Held samples of both chains
    aoesr_sample_t user_sample;
    aoesr_sample_t stab_sample;
    aoesr_sample_t sel_sample;

    // Flag vectors
    logic [EMB_FLAGS-1:0] emb_set;
    logic [EMB_FLAGS-1:0] emb_clear;
    logic [EMB_FLAGS-1:0] emb_flags;
    logic [MACHINES-1:0] machine_clear;
    logic [MACHINES-1:0] machine_flags;
    logic [BYTE_W-1:0] emb_byte;

    // Decode of the current request
    logic rd_req;
    logic wr_req;
    logic is_axis_low;
    logic is_axis_high;
    logic [1:0] axis_sel;
    logic [AXIS_W-1:0] axis_word;
    logic addr_hit;
    logic port_idx;

    // Status byte decode
    logic is_emb_status;
    logic is_machine_low;
    logic is_machine_high;

    // High byte shadows, one per port, for coherent 16-bit reads
    logic [BYTE_W-1:0] shadow_q [2];
    logic [1:0] shadow_axis_q [2];
    logic shadow_vld_q [2];

    // Answer registers
    logic [BYTE_W-1:0] rsp_data_d;
    logic [BYTE_W-1:0] rsp_data_q;
    logic rsp_valid_q;
    logic rsp_hit_q;
    logic write_dropped_q;

    // Both chains keep sampling; the port only steers the read
    // User chain: sample of the primary port path
    aoesr_sample_hold u_user_hold (
        .sys_clk_i(sys_clk_i),
        .reset_i(reset_i),
        .sample_valid_i(user_sample_valid_i),
        .sample_i(user_sample_i),
        .sample_o(user_sample),
        .fresh_o(user_fresh_o)
    );

    // Stabilization chain: sample of the auxiliary port path
    aoesr_sample_hold u_stab_hold (
        .sys_clk_i(sys_clk_i),
        .reset_i(reset_i),
        .sample_valid_i(stab_sample_valid_i),
        .sample_i(stab_sample_i),
        .sample_o(stab_sample),
        .fresh_o(stab_fresh_o)
    );

    // Request qualifiers
    assign rd_req = req_valid_i && !req_i.write;
    assign wr_req = req_valid_i && req_i.write;
    assign port_idx = req_i.aux;

    // Status byte decode, shared by the flag clear and the address hit
    assign is_emb_status = req_i.addr == ADDR_EMBEDDED_EVENT_STATUS;
    assign is_machine_low = req_i.addr == ADDR_STATE_MACHINE_STATUS_LOW;
    assign is_machine_high = req_i.addr == ADDR_STATE_MACHINE_STATUS_HIGH;

    // Axis decode from the address; low bytes sit on even addresses
    // Gaps between the axis and status addresses decode as unmapped
    always_comb begin
        is_axis_low = 1'b0;
        is_axis_high = 1'b0;
        axis_sel = AXIS_SEL_RESET;
        case (req_i.addr)
            ADDR_ACCEL_X_LOW: begin
                is_axis_low = 1'b1;
                axis_sel = 2'h0;
            end
            ADDR_ACCEL_X_HIGH: begin
                is_axis_high = 1'b1;
                axis_sel = 2'h0;
            end
            ADDR_ACCEL_Y_LOW: begin
                is_axis_low = 1'b1;
                axis_sel = 2'h1;
            end
            ADDR_ACCEL_Y_HIGH: begin
                is_axis_high = 1'b1;
                axis_sel = 2'h1;
            end
            ADDR_ACCEL_Z_LOW: begin
                is_axis_low = 1'b1;
                axis_sel = 2'h2;
            end
            ADDR_ACCEL_Z_HIGH: begin
                is_axis_high = 1'b1;
                axis_sel = 2'h2;
            end
            default: begin
                is_axis_low = 1'b0;
                is_axis_high = 1'b0;
                axis_sel = AXIS_SEL_RESET;
            end
        endcase
    end

    assign sel_sample = req_i.aux ? stab_sample : user_sample;

    always_comb begin
        case (axis_sel)
            2'h0: axis_word = sel_sample.x;
            2'h1: axis_word = sel_sample.y;
            2'h2: axis_word = sel_sample.z;
            default: axis_word = AXIS_RESET;
        endcase
    end

    assign emb_set = {emb_event_i.long_counter, emb_event_i.sig_motion, emb_event_i.tilt, emb_event_i.step};

    // Reading a status byte clears what it reported; set still wins
    // A write never clears, so a host probing with writes loses no event
    assign emb_clear = {EMB_FLAGS{rd_req && is_emb_status}};
    assign machine_clear[BYTE_W-1:0] = {BYTE_W{rd_req && is_machine_low}};
    assign machine_clear[MACHINES-1:BYTE_W] = {BYTE_W{rd_req && is_machine_high}};

    aoesr_flag_latch #(
        .WIDTH(EMB_FLAGS)
    ) u_emb_flags (
        .sys_clk_i(sys_clk_i),
        .reset_i(reset_i),
        .set_i(emb_set),
        .clear_i(emb_clear),
        .flags_o(emb_flags)
    );

    aoesr_flag_latch #(
        .WIDTH(MACHINES)
    ) u_machine_flags (
        .sys_clk_i(sys_clk_i),
        .reset_i(reset_i),
        .set_i(machine_event_i),
        .clear_i(machine_clear),
        .flags_o(machine_flags)
    );

    // Spare bits tie to zero so no stale state leaks out
    // embedded byte layout, spare bits zero
    always_comb begin
        emb_byte = BYTE_RESET;
        emb_byte[POS_LONG_COUNTER_TIMEOUT] = emb_flags[3];
        emb_byte[POS_SIGNIFICANT_MOTION] = emb_flags[2];
        emb_byte[POS_TILT] = emb_flags[1];
        emb_byte[POS_STEP] = emb_flags[0];
    end

    // Mapped addresses of this group
    assign addr_hit = is_axis_low || is_axis_high
        || is_emb_status
        || is_machine_low
        || is_machine_high;

    // Read data mux; unmapped addresses answer zero
    // Taken before the flag clear, so a read shows what it clears
    always_comb begin
        rsp_data_d = BYTE_RESET;
        if (is_axis_low) begin
            rsp_data_d = axis_word[BYTE_W-1:0];
        end else if (is_axis_high) begin
            // Shadow keeps the pair from one sample if a new one landed
            if (shadow_vld_q[port_idx] && shadow_axis_q[port_idx] == axis_sel) begin
                rsp_data_d = shadow_q[port_idx];
            end else begin
                rsp_data_d = axis_word[AXIS_W-1:BYTE_W];
            end
        end else begin
            case (req_i.addr)
                ADDR_EMBEDDED_EVENT_STATUS: rsp_data_d = emb_byte;
                ADDR_STATE_MACHINE_STATUS_LOW: rsp_data_d = machine_flags[BYTE_W-1:0];
                ADDR_STATE_MACHINE_STATUS_HIGH: rsp_data_d = machine_flags[MACHINES-1:BYTE_W];
                default: rsp_data_d = BYTE_RESET;
            endcase
        end
    end

    // Per-port high byte shadow, taken on a low byte read
    // Limitation: any other read on the same port between the two halves
    // loses the pair, and the high byte is then read live
    genvar p;
    generate
        for (p = 0; p < 2; p = p + 1) begin : g_shadow
            always_ff @(posedge sys_clk_i) begin
                if (reset_i) begin
                    shadow_q[p] <= BYTE_RESET;
                    shadow_axis_q[p] <= AXIS_SEL_RESET;
                    shadow_vld_q[p] <= 1'b0;
                end else if (rd_req && port_idx == 1'(p)) begin
                    if (is_axis_low) begin
                        shadow_q[p] <= axis_word[AXIS_W-1:BYTE_W];
                        shadow_axis_q[p] <= axis_sel;
                        shadow_vld_q[p] <= 1'b1;
                    end else begin
                        // Any other read of this port ends the pair
                        shadow_vld_q[p] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    // Answer one cycle after the read is taken
    // Data held between answers so a slow host may take it late
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            rsp_valid_q <= 1'b0;
            rsp_hit_q <= 1'b0;
            rsp_data_q <= BYTE_RESET;
        end else begin
            rsp_valid_q <= rd_req;
            rsp_hit_q <= rd_req && addr_hit;
            if (rd_req) begin
                rsp_data_q <= rsp_data_d;
            end
        end
    end

    // Write data has no path into any stored value
    // writes change nothing, mapped ones only flagged
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            write_dropped_q <= 1'b0;
        end else begin
            write_dropped_q <= wr_req && addr_hit;
        end
    end

    // Outputs
    // Status outputs are flop values rearranged, no extra stage
    assign rsp_valid_o = rsp_valid_q;
    assign rsp_data_o = rsp_data_q;
    assign rsp_hit_o = rsp_hit_q;
    assign write_dropped_o = write_dropped_q;
    assign embedded_event_status_o = emb_byte;
    assign state_machine_status_o = machine_flags;

endmodule

// [logic/aoesr_sample_hold.sv]
`timescale 1ns/1ps
// Holds the last complete sample of one acceleration chain
module aoesr_sample_hold (
    input wire logic sys_clk_i,
    input wire logic reset_i,
    input wire logic sample_valid_i,
    input wire aoesr_pkg::aoesr_sample_t sample_i,
    output aoesr_pkg::aoesr_sample_t sample_o,
    output logic fresh_o
);
    import aoesr_pkg::*;

    aoesr_sample_t sample_q;
    logic fresh_q;

    // All three axes taken together so a read never mixes two samples
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            sample_q <= {AXIS_RESET, AXIS_RESET, AXIS_RESET};
        end else if (sample_valid_i) begin
            sample_q <= sample_i;
        end
    end

    // Set once the first sample arrived
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            fresh_q <= 1'b0;
        end else if (sample_valid_i) begin
            fresh_q <= 1'b1;
        end
    end

    assign sample_o = sample_q;
    assign fresh_o = fresh_q;

endmodule

// [test/aoesr_host_model.sv]
`timescale 1ns/1ps
// Host side of the register port, one access at a time
module aoesr_host_model (
    input wire logic sys_clk_i,
    output logic req_valid_o,
    output aoesr_pkg::aoesr_req_t req_o
);
    import aoesr_pkg::*;
    initial begin
        req_valid_o = 1'b0;
        req_o = '0;
    end
    // Held over one sampling edge; fields scrambled once released
    task automatic access(input logic wr, input logic aux, input logic [7:0] addr, input logic [7:0] wdata);
        @(negedge sys_clk_i);
        req_valid_o = 1'b1;
        req_o = {wr, aux, addr, wdata};
        @(negedge sys_clk_i);
        req_valid_o = 1'b0;
        req_o = ~req_o;
    endtask
endmodule

// [test/aoesr_regs_assertions.sv]
`timescale 1ns/1ps
module aoesr_regs_checker (
    input wire logic sys_clk_i,
    input wire logic reset_i,
    input wire logic req_valid_i,
    input wire aoesr_pkg::aoesr_req_t req_i,
    input wire logic rsp_valid_o,
    input wire logic [aoesr_pkg::BYTE_W-1:0] rsp_data_o,
    input wire logic rsp_hit_o,
    input wire logic write_dropped_o,
    input wire aoesr_pkg::aoesr_emb_evt_t emb_event_i,
    input wire logic [aoesr_pkg::MACHINES-1:0] machine_event_i,
    input wire logic [aoesr_pkg::BYTE_W-1:0] embedded_event_status_o,
    input wire logic [aoesr_pkg::MACHINES-1:0] state_machine_status_o
);
    import aoesr_pkg::*;
    // Addresses owned by this group
    function automatic logic mapped(input logic [7:0] a);
        return (a >= 8'h28 && a <= 8'h2d) || (a >= 8'h35 && a <= 8'h37);
    endfunction
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (reset_i);
    logic rd;
    assign rd = req_valid_i && !req_i.write;
    a_read_answer_next: assert property (rd |=> rsp_valid_o && rsp_hit_o == mapped($past(req_i.addr)))
        else $error("read not answered next cycle");
    a_write_no_answer: assert property (req_valid_i && req_i.write
        |=> !rsp_valid_o && write_dropped_o == mapped($past(req_i.addr)))
        else $error("write answered or drop flag wrong");
    a_unmapped_reads_zero: assert property (rd && !mapped(req_i.addr) |=> rsp_data_o == 8'h00)
        else $error("unmapped read not zero");
    a_emb_fixed_zeros: assert property ((embedded_event_status_o & 8'h47) == 8'h00)
        else $error("fixed zero bit set");
    a_sigmot_flag_sets: assert property (emb_event_i.sig_motion |=> embedded_event_status_o[5])
        else $error("motion flag not set");
    a_tilt_flag_sets: assert property (emb_event_i.tilt |=> embedded_event_status_o[4])
        else $error("tilt flag not set");
    a_step_flag_sets: assert property (emb_event_i.step |=> embedded_event_status_o[3])
        else $error("step flag not set");
    a_machine_flags_set: assert property (machine_event_i != '0
        |=> (state_machine_status_o & $past(machine_event_i)) == $past(machine_event_i))
        else $error("machine flag not set");
    a_emb_read_data: assert property (rd && req_i.addr == 8'h35 |=> rsp_data_o == $past(embedded_event_status_o))
        else $error("event byte read wrong");
    a_low_fsm_read: assert property (rd && req_i.addr == 8'h36
        |=> rsp_data_o == $past(state_machine_status_o[7:0]))
        else $error("low machine byte read wrong");
    a_high_fsm_read: assert property (rd && req_i.addr == 8'h37
        |=> rsp_data_o == $past(state_machine_status_o[15:8]))
        else $error("high machine byte read wrong");
endmodule
bind aoesr_regs aoesr_regs_checker u_chk (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .req_valid_i(req_valid_i),
    .req_i(req_i), .rsp_valid_o(rsp_valid_o), .rsp_data_o(rsp_data_o), .rsp_hit_o(rsp_hit_o),
    .write_dropped_o(write_dropped_o), .emb_event_i(emb_event_i), .machine_event_i(machine_event_i),
    .embedded_event_status_o(embedded_event_status_o), .state_machine_status_o(state_machine_status_o));

// [test/aoesr_regs_test.sv]
`timescale 1ns/1ps
module aoesr_regs_test;
    import aoesr_pkg::*;
    logic sys_clk_i, reset_i, req_valid_i, rsp_valid_o, rsp_hit_o, write_dropped_o;
    logic user_sample_valid_i, stab_sample_valid_i, user_fresh_o, stab_fresh_o;
    aoesr_req_t req_i;
    aoesr_sample_t user_sample_i, stab_sample_i, usmp, ssmp;
    aoesr_emb_evt_t emb_event_i;
    logic [7:0] rsp_data_o, embedded_event_status_o;
    logic [15:0] machine_event_i, state_machine_status_o;
    logic [8:0] exp_q[$];
    logic [31:0] seed;
    logic [95:0] pool;
    int fails, checks;
    initial begin
        sys_clk_i = 1'b0;
        forever #2.5 sys_clk_i = ~sys_clk_i;
    end
    aoesr_regs u_dut (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .req_valid_i(req_valid_i), .req_i(req_i),
        .rsp_valid_o(rsp_valid_o), .rsp_data_o(rsp_data_o), .rsp_hit_o(rsp_hit_o),
        .write_dropped_o(write_dropped_o), .user_sample_valid_i(user_sample_valid_i),
        .user_sample_i(user_sample_i), .stab_sample_valid_i(stab_sample_valid_i), .stab_sample_i(stab_sample_i),
        .user_fresh_o(user_fresh_o), .stab_fresh_o(stab_fresh_o), .emb_event_i(emb_event_i),
        .machine_event_i(machine_event_i), .embedded_event_status_o(embedded_event_status_o),
        .state_machine_status_o(state_machine_status_o));
    aoesr_host_model u_host (.sys_clk_i(sys_clk_i), .req_valid_o(req_valid_i), .req_o(req_i));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Expectation noted before the request goes out
    task automatic rd(input logic aux, input logic [7:0] addr, input logic [8:0] exp);
        exp_q.push_back(exp);
        u_host.access(1'b0, aux, addr, 8'h00);
    endtask
    task automatic results();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // Answers compared mid-cycle, against the oldest note
    always @(negedge sys_clk_i) begin
        if (rsp_valid_o === 1'b1) begin
            check("answer", {rsp_hit_o, rsp_data_o}, exp_q.size() > 0 ? exp_q.pop_front() : 9'h1ff);
        end
    end
    initial begin
        reset_i = 1'b1;
        {user_sample_valid_i, stab_sample_valid_i} = 2'b00;
        user_sample_i = '0;
        stab_sample_i = '0;
        emb_event_i = '0;
        machine_event_i = '0;
        fails = 0;
        checks = 0;
        seed = 32'h8463;
        repeat (2) @(negedge sys_clk_i);
        reset_i = 1'b0;
        check("flags", {1'b0, embedded_event_status_o}, 9'h000);
        // Random samples, most negative X on the user chain
        for (int i = 0; i < 6; i++) begin
            seed = lfsr(seed);
            pool[i*16 +: 16] = seed[15:0];
        end
        {usmp, ssmp} = pool;
        usmp.x = 16'h8000;
        @(negedge sys_clk_i);
        {user_sample_valid_i, stab_sample_valid_i} = 2'b11;
        user_sample_i = usmp;
        stab_sample_i = ssmp;
        @(negedge sys_clk_i);
        {user_sample_valid_i, stab_sample_valid_i} = 2'b00;
        user_sample_i = ~usmp;
        stab_sample_i = ~ssmp;
        check("fresh", {7'h00, user_fresh_o, stab_fresh_o}, 9'h003);
        for (int p = 0; p < 2; p++) begin
            for (int a = 0; a < 6; a++) begin
                pool[47:0] = p ? ssmp : usmp;
                rd(p[0], ADDR_ACCEL_X_LOW + a[7:0], {1'b1, pool[(2-a/2)*16 + (a%2)*8 +: 8]});
            end
        end
        $display("test axis reads done");
        // Every mix of embedded events, with random machine events
        for (int e = 0; e < 16; e++) begin
            @(negedge sys_clk_i);
            emb_event_i = e[3:0];
            seed = lfsr(seed);
            machine_event_i = seed[15:0];
            @(negedge sys_clk_i);
            emb_event_i = '0;
            machine_event_i = '0;
            check("flags", {1'b0, embedded_event_status_o}, {1'b0, e[3], 1'b0, e[2:0], 3'b000});
            check("machines", {1'b0, state_machine_status_o[7:0]}, {1'b0, seed[7:0]});
            check("machines", {1'b0, state_machine_status_o[15:8]}, {1'b0, seed[15:8]});
            rd(e[0], ADDR_EMBEDDED_EVENT_STATUS, {1'b1, e[3], 1'b0, e[2:0], 3'b000});
            rd(1'b0, ADDR_STATE_MACHINE_STATUS_LOW, {1'b1, seed[7:0]});
            rd(1'b1, ADDR_STATE_MACHINE_STATUS_HIGH, {1'b1, seed[15:8]});
            rd(1'b0, ADDR_EMBEDDED_EVENT_STATUS, 9'h100);
        end
        $display("test event flags done");
        // Writes are dropped, mapped or not
        u_host.access(1'b1, 1'b0, ADDR_ACCEL_X_LOW, 8'h5a);
        check("dropped", {8'h00, write_dropped_o}, 9'h001);
        u_host.access(1'b1, 1'b1, 8'h30, 8'hff);
        check("dropped", {8'h00, write_dropped_o}, 9'h000);
        seed = lfsr(seed);
        machine_event_i = seed[15:0];
        u_host.access(1'b1, 1'b0, ADDR_STATE_MACHINE_STATUS_LOW, 8'h00);
        machine_event_i = '0;
        rd(1'b0, ADDR_ACCEL_X_LOW, {1'b1, usmp.x[7:0]});
        rd(1'b1, ADDR_ACCEL_X_HIGH, {1'b1, ssmp.x[15:8]});
        rd(1'b0, ADDR_STATE_MACHINE_STATUS_LOW, {1'b1, seed[7:0]});
        rd(1'b0, 8'h30, 9'h000);
        // New sample between the halves: high byte from the old sample
        rd(1'b0, ADDR_ACCEL_Y_LOW, {1'b1, usmp.y[7:0]});
        user_sample_valid_i = 1'b1;
        user_sample_i = ~usmp;
        @(negedge sys_clk_i);
        user_sample_valid_i = 1'b0;
        rd(1'b0, ADDR_ACCEL_Y_HIGH, {1'b1, usmp.y[15:8]});
        rd(1'b0, ADDR_ACCEL_Y_HIGH, {1'b1, ~usmp.y[15:8]});
        // Event in the clearing read's cycle survives the clear
        emb_event_i.tilt = 1'b1;
        rd(1'b0, ADDR_EMBEDDED_EVENT_STATUS, 9'h110);
        emb_event_i.tilt = 1'b0;
        rd(1'b0, ADDR_EMBEDDED_EVENT_STATUS, 9'h110);
        rd(1'b0, ADDR_EMBEDDED_EVENT_STATUS, 9'h100);
        // Second reset empties the samples
        reset_i = 1'b1;
        @(negedge sys_clk_i);
        reset_i = 1'b0;
        rd(1'b1, ADDR_ACCEL_Z_HIGH, 9'h100);
        repeat (3) @(negedge sys_clk_i);
        check("pending", {8'h00, exp_q.size() == 0}, 9'h001);
        $display("test writes and reset done");
        results();
    end
    // Whole run is a few hundred cycles
    initial begin
        #50000;
        fails++;
        results();
    end
endmodule
